/* File: hw/ccp_top.sv */
// Clock output pin controller with Wishbone register slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`default_nettype none
module ccp_top
    import ccp_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire ccp_wb_req_type wb_req_i,
    output var ccp_wb_rsp_type wb_rsp_o,
    // Clock sources
    input wire logic fast_oscillator_i,
    input wire logic slow_oscillator_i,
    input wire logic timer_a_out_clock_i,
    input wire logic timer_b_out_clock_i,
    // Output port pins
    output var ccp_pins_type pins_o,
    // Timer control
    output var ccp_timer_ctl_type timer_ctl_o
);
    ccp_state_type s_q, s_d;

    logic fast_div_out_en, slow_div_out_en;
    logic [2:0] fast_sel, slow_sel;
    logic fast_div_clock, slow_div_clock;
    logic pin_a_clk_on, pin_b_clk_on;
    logic pin_a_clk, pin_b_clk;
    logic bus_req, bus_wr;
    logic [29:0] bus_idx;

    assign fast_div_out_en = s_q.div_ctrl[FAST_EN_BIT];
    assign slow_div_out_en = s_q.div_ctrl[SLOW_EN_BIT];
    assign fast_sel = s_q.div_ctrl[FAST_SEL_LSB +: 3];
    assign slow_sel = s_q.div_ctrl[SLOW_SEL_LSB +: 3];
    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~s_q.rsp.ack;
    assign bus_wr = bus_req & wb_req_i.we & wb_req_i.sel[0];
    assign bus_idx = wb_req_i.adr[31:2];

    // Code n picks 2^n division; code 0 passes the filtered oscillator
    function automatic logic div_tap(input ccp_osc_type o,
                                     input logic [2:0] code);
        logic r;
        r = o.lvl;
        if (code != 3'h0) begin
            r = o.cnt[code - 3'h1];
        end
        return r;
    endfunction

    // Oscillator pins: change accepted once stages two and three agree
    function automatic ccp_osc_type osc_step(input ccp_osc_type o,
                                             input logic pin);
        ccp_osc_type n;
        n = o;
        n.sync = {o.sync[SYNC_LEN-2:0], pin};
        if (o.sync[1] == o.sync[2]) begin
            n.lvl = o.sync[2];
            if (o.sync[2] && !o.lvl) begin
                n.cnt = o.cnt + 7'h01;
            end
        end
        return n;
    endfunction

    assign fast_div_clock = div_tap(s_q.fast, fast_sel); // R10
    assign slow_div_clock = div_tap(s_q.slow, slow_sel); // R9

    // Oscillator source takes the pin if software enables both
    always_comb begin // R1 R2
        pin_a_clk_on = 1'b0;
        pin_a_clk = 1'b1;
        pin_b_clk_on = 1'b0;
        pin_b_clk = 1'b1;
        if (fast_div_out_en) begin // R17
            pin_a_clk_on = 1'b1;
            pin_a_clk = fast_div_clock;
        end else if (s_q.a_out_en && !s_q.tmr.chain) begin // R3
            pin_a_clk_on = 1'b1;
            pin_a_clk = timer_a_out_clock_i;
        end
        if (slow_div_out_en) begin // R17
            pin_b_clk_on = 1'b1;
            pin_b_clk = slow_div_clock;
        end else if (s_q.b_out_en) begin // R12
            pin_b_clk_on = 1'b1;
            pin_b_clk = timer_b_out_clock_i;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.fast = osc_step(s_q.fast, fast_oscillator_i);
        s_d.slow = osc_step(s_q.slow, slow_oscillator_i);
        s_d.tmr.a_reload = 1'b0;
        s_d.tmr.b_reload = 1'b0;

        // Gating is a plain mux; enable edges may chop a pulse
        s_d.pins.oe = ~s_q.float_bits; // R13
        s_d.pins.drive[PIN_A] = s_q.level_bits[PIN_A] & pin_a_clk; // R4 R5 R6
        s_d.pins.drive[PIN_B] = s_q.level_bits[PIN_B] & pin_b_clk; // R4 R5 R6
        s_d.pins.drive[PIN_SPARE] = s_q.level_bits[PIN_SPARE]; // R14

        // Single-wait classic cycle; unmapped reads return zero
        s_d.rsp.ack = bus_req;
        s_d.rsp.dat = 32'h00000000;
        if (bus_req) begin
            unique case (bus_idx)
                DIV_CTRL_IDX: begin
                    s_d.rsp.dat[7:0] = s_q.div_ctrl;
                end
                TMR_A_IDX: begin
                    s_d.rsp.dat[TMR_CHAIN_BIT] = s_q.tmr.chain;
                    s_d.rsp.dat[TMR_OUT_EN_BIT] = s_q.a_out_en;
                    s_d.rsp.dat[TMR_RUN_BIT] = s_q.tmr.a_run;
                    s_d.rsp.dat[TMR_SRC_BIT] = s_q.tmr.a_src_sel;
                end
                TMR_B_IDX: begin
                    s_d.rsp.dat[TMR_OUT_EN_BIT] = s_q.b_out_en;
                    s_d.rsp.dat[TMR_RUN_BIT] = s_q.tmr.b_run;
                    s_d.rsp.dat[TMR_SRC_BIT] = s_q.tmr.b_src_sel;
                end
                FLOAT_IDX: begin
                    s_d.rsp.dat[2:0] = s_q.float_bits;
                end
                LEVEL_IDX: begin
                    s_d.rsp.dat[2:0] = s_q.level_bits;
                end
                default: begin
                    s_d.rsp.dat = 32'h00000000;
                end
            endcase
        end
        if (bus_wr) begin
            unique case (bus_idx)
                DIV_CTRL_IDX: begin
                    s_d.div_ctrl = wb_req_i.dat[7:0]; // R9 R10
                end
                TMR_A_IDX: begin
                    s_d.tmr.chain = wb_req_i.dat[TMR_CHAIN_BIT]; // R15
                    s_d.a_out_en = wb_req_i.dat[TMR_OUT_EN_BIT]; // R11
                    s_d.tmr.a_run = wb_req_i.dat[TMR_RUN_BIT];
                    s_d.tmr.a_reload = wb_req_i.dat[TMR_RELOAD_BIT];
                    s_d.tmr.a_src_sel = wb_req_i.dat[TMR_SRC_BIT];
                end
                TMR_B_IDX: begin
                    s_d.b_out_en = wb_req_i.dat[TMR_OUT_EN_BIT]; // R12
                    s_d.tmr.b_run = wb_req_i.dat[TMR_RUN_BIT];
                    s_d.tmr.b_reload = wb_req_i.dat[TMR_RELOAD_BIT];
                    s_d.tmr.b_src_sel = wb_req_i.dat[TMR_SRC_BIT];
                end
                FLOAT_IDX: begin
                    s_d.float_bits = wb_req_i.dat[2:0]; // R13
                end
                LEVEL_IDX: begin
                    s_d.level_bits = wb_req_i.dat[2:0]; // R14
                end
                default: begin
                    s_d.level_bits = s_q.level_bits;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.div_ctrl <= DIV_CTRL_RST; // R10
            s_q.float_bits <= FLOAT_RST; // R13
            s_q.level_bits <= LEVEL_RST; // R14
            s_q.pins.drive <= LEVEL_RST;
            s_q.pins.oe <= ~FLOAT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp_o = s_q.rsp;
    assign pins_o = s_q.pins;
    assign timer_ctl_o = s_q.tmr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic wr_t0;
    assign wr_t0 = bus_wr && bus_idx == TMR_A_IDX;

    sequence s_wr_t0_en;
        wr_t0 && wb_req_i.dat[TMR_OUT_EN_BIT];
    endsequence

    sequence s_pin_a_high_idle;
        s_q.level_bits[PIN_A] && !pin_a_clk_on;
    endsequence

    sequence s_req_start;
        wb_req_i.cyc && wb_req_i.stb && !s_q.rsp.ack;
    endsequence

    chk_level_forces_low: assert property ( // R6
        !s_q.level_bits[PIN_B] |=> !pins_o.drive[PIN_B])
        else $error("pin b not low with level bit clear");

    chk_idle_holds_high: assert property ( // R5
        s_pin_a_high_idle ##1 s_pin_a_high_idle |=> pins_o.drive[PIN_A])
        else $error("pin a not high with clock off");

    chk_float_no_drive: assert property ( // R13
        s_q.float_bits[PIN_A] |=> !pins_o.oe[PIN_A])
        else $error("pin a driven while floating");

    chk_reset_values: assert property ( // R14
        disable iff (1'b0) rst_i |=> s_q.level_bits == LEVEL_RST
            && s_q.float_bits == FLOAT_RST && !s_q.a_out_en)
        else $error("reset values wrong");

    chk_chain_blocks_a: assert property ( // R3
        s_q.tmr.chain && !fast_div_out_en && s_q.level_bits[PIN_A]
            |=> pins_o.drive[PIN_A])
        else $error("timer a clock leaked in chained mode");

    chk_osc_wins: assert property ( // R17
        fast_div_out_en && s_q.a_out_en && s_q.level_bits[PIN_A]
            |=> pins_o.drive[PIN_A] == $past(fast_div_clock))
        else $error("pin a not carrying oscillator clock");

    chk_timer_b_path: assert property ( // R12
        s_q.b_out_en && !slow_div_out_en && s_q.level_bits[PIN_B]
            |=> pins_o.drive[PIN_B] == $past(timer_b_out_clock_i))
        else $error("pin b not carrying timer b clock");

    chk_div_one_pass: assert property ( // R9
        slow_div_out_en && slow_sel == 3'h0 && s_q.level_bits[PIN_B]
            |=> pins_o.drive[PIN_B] == $past(s_q.slow.lvl))
        else $error("slow divide by one wrong");

    chk_timer_a_write: assert property ( // R11
        s_wr_t0_en |=> s_q.a_out_en ##1 s_q.a_out_en || wr_t0)
        else $error("timer a enable not stored");

    sequence s_pin_b_high_idle;
        s_q.level_bits[PIN_B] && !pin_b_clk_on;
    endsequence

    chk_idle_b_high: assert property ( // R5
        s_pin_b_high_idle |=> pins_o.drive[PIN_B])
        else $error("pin b not high with clock off");

    chk_level_a_low: assert property ( // R6
        !s_q.level_bits[PIN_A] |=> !pins_o.drive[PIN_A])
        else $error("pin a not low with level bit clear");

    chk_oe_follows_float: assert property ( // R13
        1'b1 |=> pins_o.oe == ~$past(s_q.float_bits))
        else $error("pin enables do not follow float bits");

    chk_spare_level: assert property ( // R14
        1'b1 |=> pins_o.drive[PIN_SPARE]
            == $past(s_q.level_bits[PIN_SPARE]))
        else $error("spare pin not at its level bit");

    chk_fast_div_one: assert property ( // R10
        fast_div_out_en && fast_sel == 3'h0 && s_q.level_bits[PIN_A]
            |=> pins_o.drive[PIN_A] == $past(s_q.fast.lvl))
        else $error("fast divide by one wrong");

    chk_timer_a_path: assert property ( // R3
        s_q.a_out_en && !s_q.tmr.chain && !fast_div_out_en
            && s_q.level_bits[PIN_A]
            |=> pins_o.drive[PIN_A] == $past(timer_a_out_clock_i))
        else $error("pin a not carrying timer a clock");

    chk_slow_wins: assert property ( // R17
        slow_div_out_en && s_q.b_out_en && s_q.level_bits[PIN_B]
            |=> pins_o.drive[PIN_B] == $past(slow_div_clock))
        else $error("pin b not carrying oscillator clock");

    chk_div_write: assert property ( // R9
        bus_wr && bus_idx == DIV_CTRL_IDX
            |=> s_q.div_ctrl == $past(wb_req_i.dat[7:0]))
        else $error("divider register write lost");

    chk_chain_write: assert property ( // R15
        wr_t0 |=> s_q.tmr.chain == $past(wb_req_i.dat[TMR_CHAIN_BIT]))
        else $error("timer chain select write lost");

    chk_timer_b_write: assert property ( // R12
        bus_wr && bus_idx == TMR_B_IDX
            |=> s_q.b_out_en == $past(wb_req_i.dat[TMR_OUT_EN_BIT]))
        else $error("timer b output enable write lost");

    chk_reload_pulse: assert property (
        wr_t0 && wb_req_i.dat[TMR_RELOAD_BIT]
            |=> timer_ctl_o.a_reload ##1 !timer_ctl_o.a_reload)
        else $error("timer a reload not a one-cycle pulse");

    chk_idle_rsp_zero: assert property (
        !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h00000000)
        else $error("read data not zero between answers");

    chk_ack_single: assert property (
        s_req_start |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not a one-cycle answer");
endmodule
`default_nettype wire

/* File: hw/ccp_pkg.sv */
// Constants and types for the clock output pin controller
// Behaviour
// R1 - Four output clocks over two pins
// R2 - One source per pin; never both
// R3 - Timer A clock only in split mode
// R4 - Float 0, level 1, enable drives clock
// R5 - Enable off with level 1 holds high
// R6 - Level bit 0 forces pin low
// R7 - Enable changes may glitch the pin
// R8 - Software stops outputs before sleep
// R9 - Slow divider bits 6:4, enable bit 7
// R10 - Fast divider bits 2:0, enable bit 3
// R11 - Timer A output enable bit 3
// R12 - Timer B output enable bit 3
// R13 - Float bits 2:0, reset to one
// R14 - Level bits 2:0, reset to one
// R15 - Timer chain select bit 7, reset zero
// R16 - Fast oscillator running while enabled
// R17 - Both enabled: oscillator clock wins
`default_nettype none
package ccp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [29:0] DIV_CTRL_IDX = 30'h0000FF14;
    localparam logic [29:0] TMR_A_IDX = 30'h0000FF30;
    localparam logic [29:0] TMR_B_IDX = 30'h0000FF31;
    localparam logic [29:0] FLOAT_IDX = 30'h0000FFD4;
    localparam logic [29:0] LEVEL_IDX = 30'h0000FFD9;
    // Field positions
    localparam int FAST_SEL_LSB = 0;
    localparam int FAST_EN_BIT = 3;
    localparam int SLOW_SEL_LSB = 4;
    localparam int SLOW_EN_BIT = 7;
    localparam int TMR_SRC_BIT = 0;
    localparam int TMR_RELOAD_BIT = 1;
    localparam int TMR_RUN_BIT = 2;
    localparam int TMR_OUT_EN_BIT = 3;
    localparam int TMR_CHAIN_BIT = 7;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_SPARE = 2;
    // Reset values
    localparam logic [7:0] DIV_CTRL_RST = 8'h00;
    localparam logic [2:0] FLOAT_RST = 3'h7;
    localparam logic [2:0] LEVEL_RST = 3'h7;
    // Pin input synchroniser depth
    localparam int SYNC_LEN = 3;
    localparam int DIV_BITS = 7;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ccp_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ccp_wb_rsp_type;

    typedef struct packed {
        logic [2:0] drive;
        logic [2:0] oe;
    } ccp_pins_type;

    typedef struct packed {
        logic chain;
        logic a_run;
        logic a_reload;
        logic a_src_sel;
        logic b_run;
        logic b_reload;
        logic b_src_sel;
    } ccp_timer_ctl_type;

    typedef struct packed {
        logic [SYNC_LEN-1:0] sync;
        logic lvl;
        logic [DIV_BITS-1:0] cnt;
    } ccp_osc_type;

    typedef struct packed {
        logic [7:0] div_ctrl;
        logic a_out_en;
        logic b_out_en;
        logic [2:0] float_bits;
        logic [2:0] level_bits;
        ccp_osc_type fast;
        ccp_osc_type slow;
        ccp_pins_type pins;
        ccp_timer_ctl_type tmr;
        ccp_wb_rsp_type rsp;
    } ccp_state_type;
endpackage
`default_nettype wire

/* File: tb/ccp_rx_model.sv */
// Receiving device model: counts rising clock edges on both clock pins
`default_nettype none
module ccp_rx_model
    import ccp_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic clr_i,
    // Pins from the controller
    input wire ccp_pins_type pins_i,
    // Edge counts per pin
    output logic [1:0][15:0] edges_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] prev_q;
    logic [1:0] seen;
    // A floating pin reads as the inverse of what it last drove
    assign seen = pins_i.drive[1:0] ^ ~pins_i.oe[1:0];
    always_ff @(posedge clk_i) begin
        prev_q <= seen;
        for (int i = 0; i < 2; i++) begin
            // A floating pin delivers no edges to the receiver
            if (clr_i) begin
                edges_o[i] <= 16'h0;
            end else if (pins_i.oe[i] && seen[i] && !prev_q[i]) begin
                edges_o[i] <= edges_o[i] + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the clock output pin controller
`default_nettype none
module tb_top
    import ccp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, clr;
    ccp_wb_req_type req;
    ccp_wb_rsp_type rsp;
    ccp_pins_type pins;
    ccp_timer_ctl_type tctl;
    logic [1:0][15:0] edges;
    logic [7:0] ph = 8'h00;
    logic [31:0] rd;
    int errors, total_checks;

    // Sources run free; fast oscillator never stops while enabled
    always @(posedge clk_i) ph <= ph + 8'h1;

    ccp_top dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(req),
        .wb_rsp_o(rsp),
        .fast_oscillator_i(ph[2]),
        .slow_oscillator_i(ph[3]),
        .timer_a_out_clock_i(ph[1]),
        .timer_b_out_clock_i(ph[4]),
        .pins_o(pins),
        .timer_ctl_o(tctl)
    );

    ccp_rx_model rx_u (
        .clk_i(clk_i),
        .clr_i(clr),
        .pins_i(pins),
        .edges_o(edges)
    );

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ack is read before the edge's own updates land
    task automatic wb(input logic we, input logic [29:0] idx,
                      input logic [7:0] wd);
        @(posedge clk_i);
        req <= '{1'h1, 1'h1, we, {idx, 2'h0}, 4'hF, {24'h0, wd}};
        do begin
            @(posedge clk_i);
        end while (!rsp.ack);
        rd = rsp.dat;
        req <= '0;
    endtask

    // Edge count over a window, one edge of slack for phase
    task automatic meas(input int p, input int win, input int exp);
        logic [15:0] got;
        repeat (8) @(posedge clk_i);
        clr <= 1'h1;
        @(posedge clk_i);
        clr <= 1'h0;
        repeat (win) @(posedge clk_i);
        got = edges[p];
        // Unknown count fails: the select turns it into X bits
        chk((got + 16'h1 >= 16'(exp) && got <= 16'(exp + 1)) ? 32'(exp)
            : 32'(got), 32'(exp));
    endtask

    task automatic t_regs;
        logic [29:0] ia [6] = '{DIV_CTRL_IDX, TMR_A_IDX, TMR_B_IDX,
                                FLOAT_IDX, LEVEL_IDX, 30'h0000FF15};
        logic [7:0] er [6] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h07, 8'h00};
        logic [7:0] ew [6] = '{8'hFF, 8'h8D, 8'h0D, 8'h07, 8'h07, 8'h00};
        chk(32'(pins), 32'h38);
        for (int i = 0; i < 6; i++) begin
            wb(1'h0, ia[i], 8'h00);
            chk(rd, 32'(er[i]));
            wb(1'h1, ia[i], 8'hFF);
            wb(1'h0, ia[i], 8'h00);
            chk(rd, 32'(ew[i]));
        end
        chk(32'(tctl), 32'h6D);
        for (int i = 0; i < 5; i++) begin
            wb(1'h1, ia[i], er[i]);
        end
    endtask

    task automatic t_level;
        wb(1'h1, FLOAT_IDX, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(32'(pins), 32'h3F);
        wb(1'h1, DIV_CTRL_IDX, 8'h08);
        wb(1'h1, LEVEL_IDX, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(32'(pins), 32'h07);
        meas(0, 256, 0);
        wb(1'h1, LEVEL_IDX, 8'h07);
    endtask

    task automatic t_div;
        for (int n = 0; n < 8; n++) begin
            wb(1'h1, DIV_CTRL_IDX, {1'h1, 3'(n), 1'h1, 3'(n)});
            meas(0, 2048, 256 >> n);
            meas(1, 2048, 128 >> n);
        end
        wb(1'h1, DIV_CTRL_IDX, 8'h00);
        meas(0, 256, 0);
        chk(32'(pins.drive), 32'h7);
    endtask

    // Both sources on each pin measured only here, to see which wins
    task automatic t_timer;
        wb(1'h1, TMR_A_IDX, 8'h08);
        meas(0, 512, 128);
        wb(1'h1, TMR_A_IDX, 8'h88);
        meas(0, 512, 0);
        chk(32'(pins.drive[0]), 32'h1);
        wb(1'h1, TMR_A_IDX, 8'h08);
        wb(1'h1, DIV_CTRL_IDX, 8'h08);
        meas(0, 512, 64);
        wb(1'h1, TMR_B_IDX, 8'h08);
        meas(1, 512, 16);
        wb(1'h1, DIV_CTRL_IDX, 8'h80);
        meas(1, 512, 32);
        wb(1'h1, TMR_B_IDX, 8'h00);
        wb(1'h1, DIV_CTRL_IDX, 8'h00);
        wb(1'h1, TMR_A_IDX, 8'h00);
        meas(0, 256, 0);
        meas(1, 256, 0);
    endtask

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #(60000 * 10);
        errors++;
        give_verdict();
    end

    initial begin
        rst_i = 1'h1;
        clr = 1'h0;
        req = '0;
        errors = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_level();
        t_div();
        t_timer();
        give_verdict();
    end
endmodule
`default_nettype wire
